// file: shared/protection_routing_regs.vh
// constants for the protection signal routing matrix
// What this block does
// RL1: first routing group odd bits route stage starts to signal output one.
// RL2: first routing group even bits route stage trips to open output.
// RL3: first routing group defaults: all trips to open, low-set overcurrent start only.
// RL4: second group odd bits route trips to signal three; even bits inert.
// RL5: third group routes starts (odd) or trips (even) to signal two.
// RL6: input 8 active blocks trips of stages whose blocking bits 1-4 set.
// RL7: blocking bit 5 lets input 8 select the second setting bank.
// RL8: blocking bit 6 latches main trip caused by overcurrent stages.
// RL9: blocking bit 7 latches main trip caused by earth-fault stages.
// RL10: blocking bit 8 lets input 8 clear latched outputs and records.
// RL11: second blocking group does the same, driven by input 9.
// RL12: function group A bits 1-3 select low-set overcurrent characteristic.
// RL13: function group A bit 4 enables breaker failure protection.
// RL14: function group A bit 5 enables high-set threshold doubling.
// RL15: function group A bit 6 blocks low-set earth fault on low-set overcurrent start.
// RL16: function group B bits 4 and 6 choose earth-fault directionality.
// RL17: function group B bits 7 and 8 are stored but unused.
// RL18: main trip drives open, starts drive signal one, trips drive signal three.
// RL19: each output is the OR of all its selected sources.
`ifndef PROTECTION_ROUTING_REGS_VH
`define PROTECTION_ROUTING_REGS_VH
// register select codes on the settings port
`define SEL_FUNC_A 3'h0
`define SEL_FUNC_B 3'h1
`define SEL_BLOCK_8 3'h2
`define SEL_BLOCK_9 3'h3
`define SEL_ROUTE_OPEN 3'h4
`define SEL_ROUTE_SIG3 3'h5
`define SEL_ROUTE_SIG2 3'h6
// reset values
`define RST_FUNC_A 8'h00
`define RST_FUNC_B 8'h00
`define RST_BLOCK 8'h00
`define RST_ROUTE_OPEN 8'hAB
`define RST_ROUTE_SIG3 8'hA5
`define RST_ROUTE_SIG2 8'h00
// blocking group fields
`define BLK_BANK 4
`define BLK_LATCH_OC 5
`define BLK_LATCH_EF 6
`define BLK_RESET 7
// function group fields
`define FA_CHAR_LSB 0
`define FA_CBFP 3
`define FA_DOUBLE 4
`define FA_EF_BLOCK 5
`define FB_EF_LOW_DIR 3
`define FB_EF_HIGH_DIR 5
`endif

// file: logic/protection_routing_matrix.v
// switch-configured routing matrix for four protection stages
`timescale 1ns/1ps
`include "protection_routing_regs.vh"
module protection_routing_matrix #(
  parameter STAGES = 4
)(
  // clock and reset
  input wire i_core_clk,
  input wire i_reset,
  // settings write port
  input wire i_set_wr,
  input wire [2:0] i_set_sel,
  input wire [7:0] i_set_wdata,
  output reg [7:0] o_set_rdata,
  // stage signals: 0 low oc, 1 high oc, 2 low ef, 3 high ef
  input wire [STAGES-1:0] i_stage_start,
  input wire [STAGES-1:0] i_stage_trip,
  // binary control inputs
  input wire i_ctrl_in8,
  input wire i_ctrl_in9,
  // routed outputs
  output reg o_open,
  output reg o_signal_one,
  output reg o_signal_two,
  output reg o_signal_three,
  output reg o_main_trip_latched,
  output reg o_record_clear,
  // stage configuration
  output reg o_second_bank,
  output reg [2:0] o_low_oc_char,
  output reg o_cbfp_enable,
  output reg o_high_oc_double,
  output reg o_low_ef_block,
  output reg o_low_ef_directional,
  output reg o_high_ef_directional
);

  reg [7:0] stage_function_select_a;
  reg [7:0] stage_function_select_b;
  reg [7:0] input8_blocking_control;
  reg [7:0] input9_blocking_control;
  reg [7:0] route_to_open_and_signal_one;
  reg [7:0] route_to_signal_three;
  reg [7:0] route_to_signal_two;
  reg latch_oc;
  reg latch_ef;
  reg next_latch_oc;
  reg next_latch_ef;
  reg next_open;
  reg next_signal_one;
  reg next_signal_two;
  reg next_signal_three;
  reg next_main_trip_latched;
  reg next_record_clear;
  reg next_second_bank;

  wire [STAGES-1:0] start_vec;
  wire [STAGES-1:0] trip_vec;
  wire [STAGES-1:0] trip_blocked;
  wire [STAGES-1:0] to_open;
  wire [STAGES-1:0] to_sig1;
  wire [STAGES-1:0] to_sig2;
  wire [STAGES-1:0] to_sig3;
  wire first_start_signal;
  wire second_start_signal;
  wire main_trip_signal;
  wire oc_trip;
  wire ef_trip;
  wire remote_reset;
  wire low_ef_suppress;
  wire latch_oc_enable;
  wire latch_ef_enable;
  wire bank_request;
  wire [7:0] group_readback;

  // read back of a stored group
  function [7:0] read_group;
    input [2:0] sel;
    input [7:0] fa, fb, b8, b9, r1, r2, r3;
    begin
      case (sel)
        `SEL_FUNC_A: read_group = fa;
        `SEL_FUNC_B: read_group = fb;
        `SEL_BLOCK_8: read_group = b8;
        `SEL_BLOCK_9: read_group = b9;
        `SEL_ROUTE_OPEN: read_group = r1;
        `SEL_ROUTE_SIG3: read_group = r2;
        `SEL_ROUTE_SIG2: read_group = r3;
        default: read_group = 8'h00;
      endcase
    end
  endfunction

  // a switch of either blocking group armed by its control input
  function ctrl_active;
    input in8;
    input in9;
    input [7:0] grp8;
    input [7:0] grp9;
    input integer pos;
    begin
      ctrl_active = (in8 & grp8[pos]) | (in9 & grp9[pos]);
    end
  endfunction

  // function group A
  always @(posedge i_core_clk)
  begin
    if (i_reset)
      stage_function_select_a <= `RST_FUNC_A;
    else if (i_set_wr && i_set_sel == `SEL_FUNC_A)
      stage_function_select_a <= i_set_wdata;
  end

  // RL17 group B, unused bits kept
  always @(posedge i_core_clk)
  begin
    if (i_reset)
      stage_function_select_b <= `RST_FUNC_B;
    else if (i_set_wr && i_set_sel == `SEL_FUNC_B)
      stage_function_select_b <= i_set_wdata;
  end

  // blocking group for input 8
  always @(posedge i_core_clk)
  begin
    if (i_reset)
      input8_blocking_control <= `RST_BLOCK;
    else if (i_set_wr && i_set_sel == `SEL_BLOCK_8)
      input8_blocking_control <= i_set_wdata;
  end

  // blocking group for input 9
  always @(posedge i_core_clk)
  begin
    if (i_reset)
      input9_blocking_control <= `RST_BLOCK;
    else if (i_set_wr && i_set_sel == `SEL_BLOCK_9)
      input9_blocking_control <= i_set_wdata;
  end

  // RL3 open and signal one routing
  always @(posedge i_core_clk)
  begin
    if (i_reset)
      route_to_open_and_signal_one <= `RST_ROUTE_OPEN;
    else if (i_set_wr && i_set_sel == `SEL_ROUTE_OPEN)
      route_to_open_and_signal_one <= i_set_wdata;
  end

  // RL3 RL4 signal three routing
  always @(posedge i_core_clk)
  begin
    if (i_reset)
      route_to_signal_three <= `RST_ROUTE_SIG3;
    else if (i_set_wr && i_set_sel == `SEL_ROUTE_SIG3)
      route_to_signal_three <= i_set_wdata;
  end

  // RL5 signal two routing, default zero
  always @(posedge i_core_clk)
  begin
    if (i_reset)
      route_to_signal_two <= `RST_ROUTE_SIG2;
    else if (i_set_wr && i_set_sel == `SEL_ROUTE_SIG2)
      route_to_signal_two <= i_set_wdata;
  end

  // RL15 low-set earth fault held off by low oc start
  assign low_ef_suppress = stage_function_select_a[`FA_EF_BLOCK] &
    i_stage_start[0];
  assign start_vec = {i_stage_start[3],
    i_stage_start[2] & ~low_ef_suppress, i_stage_start[1:0]};

  genvar g;
  generate
    for (g = 0; g < STAGES; g = g + 1)
    begin : gen_stage
      // RL6 RL11 trip blocking
      assign trip_blocked[g] = ctrl_active(i_ctrl_in8, i_ctrl_in9,
        input8_blocking_control, input9_blocking_control, g);
      // RL15 trip held off too
      assign trip_vec[g] = i_stage_trip[g] & ~trip_blocked[g] &
        ~(low_ef_suppress & (g == 2));
      // RL1 starts to signal one
      assign to_sig1[g] = start_vec[g] & route_to_open_and_signal_one[2*g];
      // RL2 trips to open
      assign to_open[g] = trip_vec[g] &
        route_to_open_and_signal_one[2*g+1];
      // RL4 odd bits only
      assign to_sig3[g] = trip_vec[g] & route_to_signal_three[2*g];
      // RL5 starts and trips
      assign to_sig2[g] = (start_vec[g] & route_to_signal_two[2*g]) |
        (trip_vec[g] & route_to_signal_two[2*g+1]);
    end
  endgenerate

  // RL19 or of sources
  assign first_start_signal = |to_sig1;
  assign second_start_signal = |to_sig3;
  assign oc_trip = |to_open[1:0];
  assign ef_trip = |to_open[3:2];
  assign main_trip_signal = oc_trip | ef_trip;

  // RL10 RL11 remote reset
  // held for as long as the armed input stays active
  assign remote_reset = ctrl_active(i_ctrl_in8, i_ctrl_in9,
    input8_blocking_control, input9_blocking_control, `BLK_RESET);

  // RL7 RL11 bank request
  assign bank_request = ctrl_active(i_ctrl_in8, i_ctrl_in9,
    input8_blocking_control, input9_blocking_control, `BLK_BANK);

  // RL8 RL9 RL11 latch armed by either group
  assign latch_oc_enable = input8_blocking_control[`BLK_LATCH_OC] |
    input9_blocking_control[`BLK_LATCH_OC];
  assign latch_ef_enable = input8_blocking_control[`BLK_LATCH_EF] |
    input9_blocking_control[`BLK_LATCH_EF];

  // stored group selected for readback
  assign group_readback = read_group(i_set_sel, stage_function_select_a,
    stage_function_select_b, input8_blocking_control,
    input9_blocking_control, route_to_open_and_signal_one,
    route_to_signal_three, route_to_signal_two);

  // next latch state and routed outputs
  // set wins, so a trip arriving with a reset is never lost
  always @*
  begin
    next_latch_oc = latch_oc;
    next_latch_ef = latch_ef;
    // RL8 RL11 overcurrent latch, set wins
    if (oc_trip & latch_oc_enable)
      next_latch_oc = 1'b1;
    else if (remote_reset)
      next_latch_oc = 1'b0;
    // RL9 RL11 earth-fault latch, set wins
    if (ef_trip & latch_ef_enable)
      next_latch_ef = 1'b1;
    else if (remote_reset)
      next_latch_ef = 1'b0;
    // RL18 main trip drives open
    next_open = main_trip_signal | latch_oc | latch_ef;
    next_main_trip_latched = latch_oc | latch_ef;
    // RL18 start signal one, trip signal three
    next_signal_one = first_start_signal;
    next_signal_three = second_start_signal;
    // RL5 RL19 signal two sources
    next_signal_two = |to_sig2;
    // RL10 record clear
    next_record_clear = remote_reset;
    // RL7 bank switch
    next_second_bank = bank_request;
  end

  // latch state
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      latch_oc <= 1'b0;
      latch_ef <= 1'b0;
    end
    else
    begin
      latch_oc <= next_latch_oc;
      latch_ef <= next_latch_ef;
    end
  end

  // relay outputs
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_open <= 1'b0;
      o_signal_one <= 1'b0;
      o_signal_two <= 1'b0;
      o_signal_three <= 1'b0;
    end
    else
    begin
      o_open <= next_open;
      o_signal_one <= next_signal_one;
      o_signal_two <= next_signal_two;
      o_signal_three <= next_signal_three;
    end
  end

  // latch, record clear and bank status
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_main_trip_latched <= 1'b0;
      o_record_clear <= 1'b0;
      o_second_bank <= 1'b0;
    end
    else
    begin
      o_main_trip_latched <= next_main_trip_latched;
      o_record_clear <= next_record_clear;
      o_second_bank <= next_second_bank;
    end
  end

  // settings readback, one cycle behind the select
  always @(posedge i_core_clk)
  begin
    if (i_reset)
      o_set_rdata <= 8'h00;
    else
      o_set_rdata <= group_readback;
  end

  // stage configuration outputs
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_low_oc_char <= 3'h0;
      o_cbfp_enable <= 1'b0;
      o_high_oc_double <= 1'b0;
      o_low_ef_block <= 1'b0;
      o_low_ef_directional <= 1'b0;
      o_high_ef_directional <= 1'b0;
    end
    else
    begin
      // RL12 characteristic select
      o_low_oc_char <= stage_function_select_a[`FA_CHAR_LSB+2:`FA_CHAR_LSB];
      // RL13 breaker failure
      o_cbfp_enable <= stage_function_select_a[`FA_CBFP];
      // RL14 threshold doubling
      o_high_oc_double <= stage_function_select_a[`FA_DOUBLE];
      // RL15 low-set earth fault block
      o_low_ef_block <= low_ef_suppress;
      // RL16 directionality
      o_low_ef_directional <= stage_function_select_b[`FB_EF_LOW_DIR];
      o_high_ef_directional <= stage_function_select_b[`FB_EF_HIGH_DIR];
    end
  end

endmodule

// file: test/protection_routing_props.sv
// port-level assertions for the routing matrix
`timescale 1ns/1ps
module protection_routing_props #(parameter STAGES = 4) (
  input wire i_core_clk, i_reset, i_set_wr, i_ctrl_in8, i_ctrl_in9,
  input wire [2:0] i_set_sel,
  input wire [7:0] i_set_wdata, o_set_rdata,
  input wire [STAGES-1:0] i_stage_start, i_stage_trip,
  input wire o_open, o_signal_one, o_signal_two, o_signal_three,
  input wire o_main_trip_latched, o_record_clear, o_second_bank
);
  wire ctl = i_ctrl_in8 | i_ctrl_in9;
  wire no_st = ~|i_stage_start;
  wire no_tr = ~|i_stage_trip;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_wr;
    i_set_wr && i_set_sel != 3'h7 ##1 !i_set_wr && $stable(i_set_sel);
  endsequence
  sequence s_idle;
    (no_tr && !o_main_trip_latched) [*2];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    i_reset |=> !(o_open | o_signal_one | o_signal_two | o_signal_three))
    else $error("outputs not cleared by reset");
  a_readback_write: assert property (
    s_wr |=> o_set_rdata == $past(i_set_wdata, 2))
    else $error("readback differs from written value");
  a_unmapped_zero: assert property (
    i_set_sel == 3'h7 |=> o_set_rdata == 8'h00)
    else $error("unmapped select reads nonzero");
  a_open_needs_trip: assert property (s_idle |=> !o_open)
    else $error("open without trip or latch");
  a_sig_one_src: assert property (no_st |=> !o_signal_one)
    else $error("signal one without start");
  a_sig_three_src: assert property (no_tr |=> !o_signal_three)
    else $error("signal three without trip");
  a_sig_two_src: assert property (no_st && no_tr |=> !o_signal_two)
    else $error("signal two without source");
  a_latch_holds: assert property (
    o_main_trip_latched && !$past(ctl) |=> o_main_trip_latched && o_open)
    else $error("latch lost without remote reset");
  a_clear_cause: assert property (o_record_clear |-> $past(ctl))
    else $error("record clear without control input");
  a_bank_cause: assert property (o_second_bank |-> $past(ctl))
    else $error("second bank without control input");
endmodule
bind protection_routing_matrix protection_routing_props #(.STAGES(STAGES))
  u_props (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_set_wr(i_set_wr),
  .i_ctrl_in8(i_ctrl_in8), .i_ctrl_in9(i_ctrl_in9), .i_set_sel(i_set_sel),
  .i_set_wdata(i_set_wdata), .o_set_rdata(o_set_rdata),
  .i_stage_start(i_stage_start), .i_stage_trip(i_stage_trip),
  .o_open(o_open), .o_signal_one(o_signal_one), .o_signal_two(o_signal_two),
  .o_signal_three(o_signal_three), .o_main_trip_latched(o_main_trip_latched),
  .o_record_clear(o_record_clear), .o_second_bank(o_second_bank));

// file: test/stage_model.sv
// behavioural protection stages: start on fault, trip after a delay
`timescale 1ns/1ps
module stage_model #(
  parameter DLY = 2
)(
  input wire i_core_clk,
  input wire [3:0] i_fault,
  input wire [3:0] i_trip_en,
  output reg [3:0] o_start = 4'h0,
  output reg [3:0] o_trip = 4'h0
);
  integer age [0:3];
  integer k;
  initial
    for (k = 0; k < 4; k = k + 1) age[k] = 0;
  always @(posedge i_core_clk)
    for (k = 0; k < 4; k = k + 1)
    begin
      age[k] <= i_fault[k] ? age[k] + 1 : 0;
      o_start[k] <= i_fault[k];
      o_trip[k] <= i_fault[k] & i_trip_en[k] & (age[k] >= DLY);
    end
endmodule

// file: test/protection_routing_matrix_tb.sv
// self-checking bench for the protection routing matrix
`timescale 1ns/1ps
`include "protection_routing_regs.vh"
module protection_routing_matrix_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg wr = 1'b0;
  reg in8 = 1'b0;
  reg in9 = 1'b0;
  reg [2:0] sel = 3'h0;
  reg [7:0] wd = 8'h00;
  reg [3:0] flt = 4'h0;
  reg [3:0] ten = 4'h0;
  wire [3:0] st, tr;
  wire [7:0] rd;
  wire [2:0] chr;
  wire op, s1, s2, s3, lat, rclr, bank, cbf, dbl, efb, efd, hfd;
  integer err_count = 0;
  integer n_tests = 0;
  integer cyc = 0;
  always #5 clk = ~clk;
  stage_model #(.DLY(2)) far (.i_core_clk(clk), .i_fault(flt),
    .i_trip_en(ten), .o_start(st), .o_trip(tr));
  protection_routing_matrix DUT (.i_core_clk(clk), .i_reset(rst),
    .i_set_wr(wr), .i_set_sel(sel), .i_set_wdata(wd), .o_set_rdata(rd),
    .i_stage_start(st), .i_stage_trip(tr), .i_ctrl_in8(in8),
    .i_ctrl_in9(in9), .o_open(op), .o_signal_one(s1), .o_signal_two(s2),
    .o_signal_three(s3), .o_main_trip_latched(lat),
    .o_record_clear(rclr), .o_second_bank(bank), .o_low_oc_char(chr),
    .o_cbfp_enable(cbf), .o_high_oc_double(dbl), .o_low_ef_block(efb),
    .o_low_ef_directional(efd), .o_high_ef_directional(hfd));
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      err_count = err_count + 1;
      finish_test;
    end
  end
  task finish_test;
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr_reg(input [2:0] s, input [7:0] d);
    sel = s;
    wd = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task rd_chk(input [2:0] s, input [7:0] e);
    sel = s;
    tick(2);
    chk(rd, e);
  endtask
  task hit(input [3:0] f, input [3:0] te);
    flt = f;
    ten = te;
    tick(6);
  endtask
  task ctl(input k, input v);
    if (k) in9 = v;
    else in8 = v;
  endtask
  function [3:0] pick(input [7:0] r, input b);
    pick = {r[6+b], r[4+b], r[2+b], r[b]};
  endfunction
  task t_defaults;
    wr_reg(3'h7, 8'hFF);
    rd_chk(3'h7, 8'h00);
    rd_chk(`SEL_FUNC_A, 8'h00);
    rd_chk(`SEL_FUNC_B, 8'h00);
    rd_chk(`SEL_BLOCK_9, 8'h00);
    rd_chk(`SEL_ROUTE_OPEN, 8'hAB);
    rd_chk(`SEL_ROUTE_SIG3, 8'hA5);
    rd_chk(`SEL_ROUTE_SIG2, 8'h00);
  endtask
  task t_route(input w, input [7:0] r1, r2, r3, input [3:0] f, te);
    if (w)
    begin
      wr_reg(`SEL_ROUTE_OPEN, r1);
      wr_reg(`SEL_ROUTE_SIG3, r2);
      wr_reg(`SEL_ROUTE_SIG2, r3);
    end
    hit(f, te);
    chk(op, |(f & te & pick(r1, 1)));
    chk(s1, |(f & pick(r1, 0)));
    chk(s3, |(f & te & pick(r2, 0)));
    chk(s2, |(f & (pick(r3, 0) | te & pick(r3, 1))));
    hit(4'h0, 4'h0);
  endtask
  task t_block(input k);
    reg [3:0] f;
    reg [2:0] s;
    f = k ? 4'h4 : 4'h1;
    s = k ? `SEL_BLOCK_9 : `SEL_BLOCK_8;
    wr_reg(`SEL_ROUTE_OPEN, 8'hAA);
    wr_reg(s, {1'b0, k, ~k, 1'b1, f});
    ctl(k, 1'b1);
    hit(f, f);
    chk(op, 0);
    chk(bank, 1);
    ctl(k, 1'b0);
    hit(f, f);
    hit(4'h0, 4'h0);
    chk(op, 1);
    chk(lat, 1);
    wr_reg(s, 8'h80);
    ctl(k, 1'b1);
    tick(2);
    chk(rclr, 1);
    chk(op, 0);
    ctl(k, 1'b0);
    tick(2);
  endtask
  task t_func;
    wr_reg(`SEL_FUNC_A, 8'h3D);
    wr_reg(`SEL_FUNC_B, 8'hE8);
    wr_reg(`SEL_ROUTE_SIG2, 8'h10);
    rd_chk(`SEL_FUNC_B, 8'hE8);
    chk({cbf, dbl, chr}, 5'h1D);
    chk({efd, hfd}, 2'h3);
    hit(4'h5, 4'h0);
    chk({efb, s2}, 2'h2);
    hit(4'h4, 4'h0);
    chk(s2, 1);
  endtask
  initial
  begin
    tick(20);
    rst = 1'b0;
    t_defaults;
    t_route(0, 8'hAB, 8'hA5, 8'h00, 4'hF, 4'hF);
    t_route(1, 8'h55, 8'hFF, 8'hAA, 4'h5, 4'h0);
    t_route(1, 8'hAA, 8'h5A, 8'h55, 4'hA, 4'hA);
    t_block(1'b0);
    t_block(1'b1);
    t_func;
    finish_test;
  end
endmodule
